// ---- verilog/cgpc_top.v ----
// core group power coordinator: pstate arbitration, gating, apb registers
`timescale 1ns/1ps
`include "cgpc_defs.vh"

// Overview of operation
// R01: group pstate follows the fastest request of the four cores.
// R02: one frequency and voltage output drives every clocked core together.
// R03: per-core voltage control allowed only while that core is clocked off.
// R04: L3 stays active until all four cores are deep enough at once.
// R05: an L2 gates only when both cores of its pair allow it.
// R06: idle levels are numbered; higher means deeper saving, slower exit.
// R07: each core is clocked and powered off on its own.
// R08: five units each have four wakeup bits, one per firmware requester.
// R09: four message queues of 64 bytes each in controller memory.
// R10: hypervisor sends pstate requests by writing the request register.
// R11: engine firmware writes the status report register read by hypervisor.
// R12: temperature converted to degrees at read time with loaded calibration.
// R13: temperature reads refused to the core management engine.
// R14: no automatic hardware action on over-temperature.
// R15: droop monitor flags one level above or three below target.
// R16: power-off exit completes within about 250 microseconds.
// R17: pstate is 8-bit unsigned, zero fastest, each step slower.
// R18: clocked-off cores are left out; reset selects the fastest pstate.
module cgpc_top #(
    parameter EXIT_CYC = `CGPC_EXIT_CYC
) (
    // clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // apb slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire        cme_access,
    output wire        pready,
    output reg  [31:0] prdata,
    output reg         pslverr,
    // cores
    input  wire [3:0]  pcr_wr,
    input  wire [31:0] pcr_pstate,
    input  wire [15:0] core_stop_lvl,
    output reg  [7:0]  group_pstate,
    output reg  [3:0]  core_clk_off,
    output reg  [3:0]  core_pwr_off,
    output reg  [3:0]  core_vctl_sep,
    output reg  [3:0]  core_waking,
    output reg  [1:0]  l2_gate,
    output reg         l3_active,
    output reg  [31:0] status_report,
    output reg  [4:0]  special_wakeup,
    // sensors
    input  wire [9:0]  temp_raw,
    input  wire [3:0]  grid_level,
    output reg         droop_hi,
    output reg         droop_lo,
    // interrupt
    output wire        irq
);
    localparam [`CGPC_CNT_W-1:0] EXIT_CNT = EXIT_CYC;

    reg [`CGPC_ST_W-1:0]  status_r;
    reg [`CGPC_ST_W-1:0]  status_nxt;
    reg [`CGPC_ST_W-1:0]  mask_r;
    reg [19:0]            wakeup_r;
    reg [`CGPC_DRP_W-1:0] droop_cfg_r;
    reg [`CGPC_CAL_W-1:0] cal_r;
    reg [7:0]             req_r [0:3];
    reg [31:0]            queue_r [0:63];
    reg [`CGPC_CNT_W-1:0] exit_cnt_r [0:3];
    reg [7:0]             ps_nxt;
    reg [3:0]             clk_off_nxt;
    reg [3:0]             lvl;
    reg                   any_on;
    reg [31:0]            rd_nxt;
    reg                   err_nxt;
    reg [3:0]             set_ev;
    integer               i;
    integer               c;

    wire       setup   = psel & ~penable;
    wire       wr_take = psel & penable & pwrite;
    wire       in_q    = (paddr >= `CGPC_A_QBASE) && (paddr <= `CGPC_A_QTOP);
    wire [5:0] q_idx   = paddr[7:2];
    wire [3:0] tgt     = droop_cfg_r[`CGPC_DRP_TGT_HI:0];

    // effective level of a core: any wakeup bit of it pulls it to zero
    function [3:0] eff_lvl;
        input [15:0] lv;
        input [19:0] wk;
        input [1:0]  c;
        begin
            if (wk[c*4 +: 4] != 4'h0)
                eff_lvl = 4'h0;
            else
                eff_lvl = lv[c*4 +: 4];
        end
    endfunction

    // scale then offset; done on each read so a new calibration acts at once
    function [31:0] to_celsius;
        input [9:0]             raw;
        input [`CGPC_CAL_W-1:0] cal;
        reg   [17:0]            prod;
        begin
            prod = raw * cal[7:0];
            to_celsius = {24'h000000, prod[`CGPC_CAL_SHIFT +: 8] + cal[15:8]};
        end
    endfunction

    assign pready = 1'b1;
    assign irq    = |(status_r & mask_r);

    // arbitration among clocked cores; fastest is the lowest value
    always @*
    begin
        ps_nxt      = `CGPC_PS_SLOWEST;
        any_on      = 1'b0;
        clk_off_nxt = 4'h0;
        lvl         = 4'h0;
        // own loop index: the clocked processes keep theirs
        for (c = 0; c < 4; c = c + 1)
        begin
            lvl = eff_lvl(core_stop_lvl, wakeup_r, c[1:0]);
            clk_off_nxt[c] = (lvl >= `CGPC_LVL_CLKOFF);        // [R06] [R07]
            if (!clk_off_nxt[c])
            begin
                any_on = 1'b1;
                if (req_r[c] < ps_nxt)                         // [R01] [R17]
                    ps_nxt = req_r[c];
            end
        end
        if (!any_on)
            ps_nxt = group_pstate;                             // [R18]
    end

    // read mux, sampled in the setup phase so prdata is a flop at access
    always @*
    begin
        rd_nxt  = 32'h00000000;
        err_nxt = 1'b0;
        if (in_q)
            rd_nxt = queue_r[q_idx];                           // [R09]
        else
        begin
            case (paddr)
            `CGPC_A_STATUS: rd_nxt = {25'h0000000, status_r};
            `CGPC_A_MASK:   rd_nxt = {25'h0000000, mask_r};
            `CGPC_A_WAKEUP: rd_nxt = {12'h000, wakeup_r};
            `CGPC_A_REPORT: rd_nxt = status_report;
            `CGPC_A_PSTATE: rd_nxt = {24'h000000, group_pstate};
            `CGPC_A_DROOP:  rd_nxt = {26'h0000000, droop_cfg_r};
            `CGPC_A_CAL:    rd_nxt = {16'h0000, cal_r};
            `CGPC_A_CORES:  rd_nxt = {16'h0000, core_stop_lvl};
            `CGPC_A_TEMP:
            begin
                if (cme_access)
                    err_nxt = 1'b1;                            // [R13]
                else
                    rd_nxt = to_celsius(temp_raw, cal_r);      // [R12]
            end
            default:        err_nxt = 1'b1;
            endcase
        end
    end

    // sticky events; a new event wins over a clear in the same cycle
    always @*
    begin
        set_ev = 4'h0;
        if (wr_take && in_q)
            set_ev[q_idx[5:4]] = 1'b1;                         // [R09]
        status_nxt = status_r;
        if (wr_take && paddr == `CGPC_A_STATUS)
            status_nxt = status_r & ~pwdata[`CGPC_ST_W-1:0];
        status_nxt[`CGPC_ST_MSG_LO +: 4] =
            status_nxt[`CGPC_ST_MSG_LO +: 4] | set_ev;
        if (droop_hi)
            status_nxt[`CGPC_ST_DRP_HI] = 1'b1;
        if (droop_lo)
            status_nxt[`CGPC_ST_DRP_LO] = 1'b1;
        if (ps_nxt != group_pstate)
            status_nxt[`CGPC_ST_PCHG] = 1'b1;
    end

    // apb registers and queue memory
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata        <= 32'h00000000;
            pslverr       <= 1'b0;
            status_r      <= {`CGPC_ST_W{1'b0}};
            mask_r        <= {`CGPC_ST_W{1'b0}};
            wakeup_r      <= 20'h00000;
            droop_cfg_r   <= {`CGPC_DRP_W{1'b0}};
            cal_r         <= `CGPC_CAL_RST;
            status_report <= 32'h00000000;
            for (i = 0; i < 64; i = i + 1)
                queue_r[i] <= 32'h00000000;
        end
        else
        begin
            status_r <= status_nxt;
            if (setup)
            begin
                prdata  <= pwrite ? 32'h00000000 : rd_nxt;
                pslverr <= err_nxt;
            end
            if (wr_take)
            begin
                if (in_q)
                    queue_r[q_idx] <= pwdata;                  // [R09]
                else
                begin
                    case (paddr)
                    `CGPC_A_MASK:   mask_r <= pwdata[`CGPC_ST_W-1:0];
                    `CGPC_A_WAKEUP: wakeup_r <= pwdata[19:0];  // [R08]
                    `CGPC_A_REPORT: status_report <= pwdata;   // [R11]
                    `CGPC_A_DROOP:
                        droop_cfg_r <= pwdata[`CGPC_DRP_W-1:0];
                    `CGPC_A_CAL:    cal_r <= pwdata[`CGPC_CAL_W-1:0];
                    default:        mask_r <= mask_r;
                    endcase
                end
            end
        end
    end

    // per-core request capture; reset means fastest
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (i = 0; i < 4; i = i + 1)
                req_r[i] <= `CGPC_PS_MAX;                      // [R18]
        end
        else
        begin
            for (i = 0; i < 4; i = i + 1)
                if (pcr_wr[i])
                    req_r[i] <= pcr_pstate[i*8 +: 8];          // [R10]
        end
    end

    // gating, group operating point and exit timers
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            group_pstate   <= `CGPC_PS_MAX;                    // [R18]
            core_clk_off   <= 4'h0;
            core_pwr_off   <= 4'h0;
            core_vctl_sep  <= 4'h0;
            core_waking    <= 4'h0;
            l2_gate        <= 2'b00;
            l3_active      <= 1'b1;
            special_wakeup <= 5'b00000;
            for (i = 0; i < 4; i = i + 1)
                exit_cnt_r[i] <= {`CGPC_CNT_W{1'b0}};
        end
        else
        begin
            group_pstate  <= ps_nxt;                           // [R02]
            core_clk_off  <= clk_off_nxt;                      // [R07]
            core_vctl_sep <= clk_off_nxt;                      // [R03]
            for (i = 0; i < 4; i = i + 1)
            begin
                special_wakeup[i] <= |wakeup_r[i*4 +: 4];      // [R08]
                if (eff_lvl(core_stop_lvl, wakeup_r, i[1:0])
                        >= `CGPC_LVL_PWROFF)
                begin
                    core_pwr_off[i]  <= 1'b1;                  // [R07]
                    core_waking[i]   <= 1'b0;
                    exit_cnt_r[i]    <= {`CGPC_CNT_W{1'b0}};
                end
                else if (core_pwr_off[i])
                begin
                    // power returns here; clocks return in the same cycle only if the level is also below CGPC_LVL_CLKOFF; waking stays high for the timer
                    core_pwr_off[i]  <= 1'b0;
                    core_waking[i]   <= 1'b1;                  // [R16]
                    exit_cnt_r[i]    <= EXIT_CNT;
                end
                else if (exit_cnt_r[i] > {`CGPC_CNT_W{1'b0}})
                    exit_cnt_r[i] <= exit_cnt_r[i] -
                                     {{(`CGPC_CNT_W-1){1'b0}}, 1'b1};
                else
                    core_waking[i] <= 1'b0;                    // [R16]
            end
            special_wakeup[4] <= |wakeup_r[19:16];             // [R08]
            // cache wakeup bits keep both caches ungated
            l2_gate[0] <= ~special_wakeup[4] &&                // [R05]
                (eff_lvl(core_stop_lvl, wakeup_r, 2'd0) >= `CGPC_LVL_L2GATE)
             && (eff_lvl(core_stop_lvl, wakeup_r, 2'd1) >= `CGPC_LVL_L2GATE);
            l2_gate[1] <= ~special_wakeup[4] &&                // [R05]
                (eff_lvl(core_stop_lvl, wakeup_r, 2'd2) >= `CGPC_LVL_L2GATE)
             && (eff_lvl(core_stop_lvl, wakeup_r, 2'd3) >= `CGPC_LVL_L2GATE);
            l3_active <= special_wakeup[4] ||                  // [R04]
                (eff_lvl(core_stop_lvl, wakeup_r, 2'd0) < `CGPC_LVL_L3GATE)
             || (eff_lvl(core_stop_lvl, wakeup_r, 2'd1) < `CGPC_LVL_L3GATE)
             || (eff_lvl(core_stop_lvl, wakeup_r, 2'd2) < `CGPC_LVL_L3GATE)
             || (eff_lvl(core_stop_lvl, wakeup_r, 2'd3) < `CGPC_LVL_L3GATE);
        end
    end

    // droop flags; indication only, like temperature no hardware reaction
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            droop_hi <= 1'b0;
            droop_lo <= 1'b0;
        end
        else
        begin
            // [R14] no thermal trip path exists in this block
            droop_hi <= droop_cfg_r[`CGPC_DRP_EN_HI] &&        // [R15]
                (grid_level >= tgt + `CGPC_DRP_ABOVE) &&
                (tgt != 4'hf);
            droop_lo <= droop_cfg_r[`CGPC_DRP_EN_LO] &&        // [R15]
                (tgt >= `CGPC_DRP_BELOW) &&
                (grid_level <= tgt - `CGPC_DRP_BELOW);
        end
    end
endmodule

// ---- verilog/cgpc_defs.vh ----
// constants for the core group power coordinator
`ifndef CGPC_DEFS_VH
`define CGPC_DEFS_VH
// register byte addresses
`define CGPC_A_STATUS    12'h000
`define CGPC_A_MASK      12'h004
`define CGPC_A_WAKEUP    12'h008
`define CGPC_A_REPORT    12'h00c
`define CGPC_A_PSTATE    12'h010
`define CGPC_A_DROOP     12'h014
`define CGPC_A_TEMP      12'h018
`define CGPC_A_CAL       12'h01c
`define CGPC_A_CORES     12'h020
`define CGPC_A_QBASE     12'h100
`define CGPC_A_QTOP      12'h1fc
// status bit positions
`define CGPC_ST_MSG_LO   0
`define CGPC_ST_DRP_HI   4
`define CGPC_ST_DRP_LO   5
`define CGPC_ST_PCHG     6
`define CGPC_ST_W        7
// droop config fields
`define CGPC_DRP_TGT_HI  3
`define CGPC_DRP_EN_HI   4
`define CGPC_DRP_EN_LO   5
`define CGPC_DRP_W       6
`define CGPC_DRP_ABOVE   4'h1
`define CGPC_DRP_BELOW   4'h3
// calibration fields: gain in [7:0], offset in [15:8]
`define CGPC_CAL_W       16
`define CGPC_CAL_RST     16'h0040
`define CGPC_CAL_SHIFT   6
// idle levels at which each saving becomes allowed
`define CGPC_LVL_CLKOFF  4'h2
`define CGPC_LVL_L2GATE  4'h4
`define CGPC_LVL_PWROFF  4'h5
`define CGPC_LVL_L3GATE  4'h8
// pstate: zero is the fastest point
`define CGPC_PS_MAX      8'h00
`define CGPC_PS_SLOWEST  8'hff
// fast exit from power-off
`define CGPC_EXIT_US     250
`define CGPC_CLK_MHZ     40
`define CGPC_EXIT_CYC    (`CGPC_EXIT_US * `CGPC_CLK_MHZ)
`define CGPC_CNT_W       16
`endif

// ---- tb/cgpc_monitor.sv ----
// concurrent checks on the coordinator ports
`timescale 1ns/1ps
`include "cgpc_defs.vh"
module cgpc_monitor #(
    parameter EXIT_CYC = 8
) (
    // clock and reset
    input wire        pclk,
    input wire        presetn,
    // apb
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire        cme_access,
    input wire        pready,
    input wire [31:0] prdata,
    input wire        pslverr,
    // cores and caches
    input wire [15:0] core_stop_lvl,
    input wire [3:0]  core_clk_off,
    input wire [3:0]  core_pwr_off,
    input wire [3:0]  core_vctl_sep,
    input wire [3:0]  core_waking,
    input wire [1:0]  l2_gate,
    input wire        l3_active,
    input wire [4:0]  special_wakeup
);
    logic [15:0] wake_cnt_r;
    default clocking mcb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // counter keeps the exit bound free of long repetitions
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            wake_cnt_r <= 16'h0;
        else if (core_waking[0])
            wake_cnt_r <= wake_cnt_r + 16'h1;
        else
            wake_cnt_r <= 16'h0;
    end
    sequence temp_setup;
        psel && !penable && !pwrite && cme_access && paddr == `CGPC_A_TEMP;
    endsequence
    sequence exit_start;
        $fell(core_pwr_off[0]);
    endsequence
    l3_keep_a: assert property (
        core_stop_lvl[15:12] < `CGPC_LVL_L3GATE |=> l3_active)
        else $error("l3 gated with core3 shallow");
    l2_pair0_a: assert property (
        core_stop_lvl[3:0] < `CGPC_LVL_L2GATE |=> !l2_gate[0])
        else $error("l2 pair0 gated with core0 shallow");
    l2_pair1_a: assert property (
        core_stop_lvl[11:8] < `CGPC_LVL_L2GATE |=> !l2_gate[1])
        else $error("l2 pair1 gated with core2 shallow");
    clk_off_a: assert property (
        core_stop_lvl[7:4] < `CGPC_LVL_CLKOFF |=> !core_clk_off[1])
        else $error("core1 clocked off while shallow");
    vctl_sep_a: assert property (core_vctl_sep == core_clk_off)
        else $error("separate voltage on a clocked core");
    pwr_clk_a: assert property ((core_pwr_off & ~core_clk_off) == 4'h0)
        else $error("core powered off but clocked");
    temp_refuse_a: assert property (
        temp_setup |=> pslverr && prdata == 32'h0)
        else $error("temperature read granted to engine");
    zero_wait_a: assert property (psel && penable |-> pready)
        else $error("apb access not ready");
    exit_wake_a: assert property (exit_start |-> core_waking[0])
        else $error("power-off exit without waking");
    wake_bound_a: assert property (wake_cnt_r < EXIT_CYC + 4)
        else $error("core0 exit too long");
    wakeup_awake_a: assert property (
        special_wakeup[0] |-> !core_clk_off[0])
        else $error("core0 clocked off under wakeup");
endmodule

bind cgpc_top cgpc_monitor #(.EXIT_CYC(EXIT_CYC)) mon (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .cme_access,
    .pready, .prdata, .pslverr, .core_stop_lvl, .core_clk_off,
    .core_pwr_off, .core_vctl_sep, .core_waking, .l2_gate, .l3_active,
    .special_wakeup
);

// ---- tb/cgpc_cores.sv ----
// model of the four cores: request writes and idle levels
`timescale 1ns/1ps
module cgpc_cores (
    // clock
    input  wire         pclk,
    // core side
    output logic [3:0]  pcr_wr,
    output logic [31:0] pcr_pstate,
    output logic [15:0] core_stop_lvl
);
    initial
    begin
        pcr_wr = 4'h0;
        pcr_pstate = 32'h0;
        core_stop_lvl = 16'h0;
    end
    task automatic request(input int c, input logic [7:0] ps);
        @(posedge pclk);
        pcr_pstate[8*c +: 8] <= ps;
        pcr_wr[c] <= 1'h1;
        @(posedge pclk);
        pcr_wr[c] <= 1'h0;
        // value not held after the pulse, so a late capture shows
        pcr_pstate[8*c +: 8] <= ~ps;
    endtask
    task automatic set_lvl(input int c, input logic [3:0] lv);
        @(posedge pclk);
        core_stop_lvl[4*c +: 4] <= lv;
    endtask
endmodule

// ---- tb/cgpc_top_bench.sv ----
// self-checking bench for the core group power coordinator
`timescale 1ns/1ps
`include "cgpc_defs.vh"
module cgpc_top_bench;
    localparam EXIT_CYC = 8;
    logic        pclk, presetn, psel, penable, pwrite, cme_access;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, pcr_pstate, status_report, q;
    logic [15:0] core_stop_lvl;
    logic [9:0]  temp_raw;
    logic [7:0]  group_pstate;
    logic [4:0]  special_wakeup;
    logic [3:0]  pcr_wr, grid_level, core_clk_off, core_pwr_off;
    logic [3:0]  core_vctl_sep, core_waking;
    logic [1:0]  l2_gate;
    logic        pready, pslverr, l3_active, droop_hi, droop_lo, irq, e;
    int          n_fail, n_compared, ticks;
    cgpc_top #(.EXIT_CYC(EXIT_CYC)) dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .cme_access, .pready, .prdata, .pslverr, .pcr_wr, .pcr_pstate,
        .core_stop_lvl, .group_pstate, .core_clk_off, .core_pwr_off,
        .core_vctl_sep, .core_waking, .l2_gate, .l3_active,
        .status_report, .special_wakeup, .temp_raw, .grid_level,
        .droop_hi, .droop_lo, .irq
    );
    cgpc_cores cores (.pclk, .pcr_wr, .pcr_pstate, .core_stop_lvl);
    initial
    begin
        pclk = 1'h0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        ticks++;
        if (ticks == 20000)
        begin
            n_fail++;
            conclude();
        end
    end
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] x, g);
        n_compared++;
        if (g !== x)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", s, x, g);
        end
    endtask
    // ends on a falling edge so registered outputs have landed
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic er);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        // only the global tick ceiling ends a stalled access
        do
            @(posedge pclk);
        while (pready !== 1'h1);
        r = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'h1, a, d, q, e);
    endtask
    task automatic rd(input string s, input logic [11:0] a,
                      input logic [31:0] x);
        apb(1'h0, a, 32'h0, q, e);
        chk(s, x, q);
    endtask
    task automatic t_regs();
        chk("group", `CGPC_PS_MAX, group_pstate);
        chk("l3", 1'h1, l3_active);
        rd("cal", `CGPC_A_CAL, 32'h40);
        apb(1'h0, 12'h0f0, 32'h0, q, e);
        chk("slverr", 1'h1, e);
        wr(`CGPC_A_REPORT, 32'ha5a5_0001);
        tick(1);
        chk("report", 32'ha5a5_0001, status_report);
        rd("report", `CGPC_A_REPORT, 32'ha5a5_0001);
    endtask
    task automatic t_temp();
        @(posedge pclk);
        temp_raw <= 10'h0a5;
        wr(`CGPC_A_CAL, 32'h0580);
        rd("temp", `CGPC_A_TEMP, 32'h4f);
        cme_access <= 1'h1;
        apb(1'h0, `CGPC_A_TEMP, 32'h0, q, e);
        cme_access <= 1'h0;
        chk("slverr", 1'h1, e);
        chk("temp", 32'h0, q);
        temp_raw <= 10'h3ff;
        tick(3);
        chk("clk_off", 4'h0, core_clk_off);
        chk("group", 8'h00, group_pstate);
    endtask
    task automatic t_droop();
        logic [3:0] gl[3] = '{4'h9, 4'h5, 4'h6};
        logic [1:0] ex[3] = '{2'h2, 2'h1, 2'h0};
        @(posedge pclk);
        grid_level <= 4'h8;
        wr(`CGPC_A_STATUS, 32'hff);
        wr(`CGPC_A_DROOP, 32'h38);
        for (int i = 0; i < 3; i++)
        begin
            @(posedge pclk);
            grid_level <= gl[i];
            tick(2);
            chk("droop", ex[i], {droop_hi, droop_lo});
        end
        rd("status", `CGPC_A_STATUS, 32'h30);
        wr(`CGPC_A_DROOP, 32'h0);
        wr(`CGPC_A_STATUS, 32'hff);
    endtask
    task automatic t_pstate();
        logic [7:0] ps[4] = '{8'h20, 8'h10, 8'h30, 8'h18};
        for (int c = 0; c < 4; c++)
            cores.request(c, ps[c]);
        tick(3);
        chk("group", 8'h10, group_pstate);
        cores.set_lvl(1, `CGPC_LVL_CLKOFF);
        tick(3);
        chk("group", 8'h18, group_pstate);
        chk("clk_off", 4'h2, core_clk_off);
        chk("vctl", 4'h2, core_vctl_sep);
        rd("pstate", `CGPC_A_PSTATE, 32'h18);
        rd("cores", `CGPC_A_CORES, 32'h20);
        chk("irq", 1'h0, irq);
        wr(`CGPC_A_MASK, 32'h40);
        tick(1);
        chk("irq", 1'h1, irq);
        wr(`CGPC_A_STATUS, 32'h40);
        tick(1);
        chk("irq", 1'h0, irq);
        rd("status", `CGPC_A_STATUS, 32'h0);
    endtask
    task automatic t_idle();
        cores.set_lvl(1, 4'h4);
        cores.set_lvl(0, 4'h4);
        tick(2);
        chk("l2", 2'h1, l2_gate);
        cores.set_lvl(1, 4'h3);
        tick(2);
        chk("l2", 2'h0, l2_gate);
        for (int c = 0; c < 4; c++)
            cores.set_lvl(c, `CGPC_LVL_L3GATE);
        tick(2);
        chk("l3", 1'h0, l3_active);
        chk("pwr_off", 4'hf, core_pwr_off);
        wr(`CGPC_A_WAKEUP, 32'h1);
        tick(1);
        chk("waking", 4'h1, core_waking);
        chk("l3", 1'h1, l3_active);
        tick(EXIT_CYC + 3);
        chk("waking", 4'h0, core_waking);
        chk("pwr_off", 4'he, core_pwr_off);
        for (int r = 0; r < 4; r++)
        begin
            wr(`CGPC_A_WAKEUP, (32'h1 << (16 + r)) | (32'h1 << (12 + r)));
            tick(1);
            chk("wakeup", 5'h18, special_wakeup);
            chk("l3", 1'h1, l3_active);
        end
        wr(`CGPC_A_WAKEUP, 32'h0);
        for (int c = 0; c < 4; c++)
            cores.set_lvl(c, 4'h0);
        tick(4);
    endtask
    task automatic t_queue();
        logic [11:0] a;
        wr(`CGPC_A_STATUS, 32'hff);
        for (int n = 0; n < 4; n++)
        begin
            a = 12'h13c + 12'(64 * n);
            wr(a, 32'hc0de_0000 + 32'(n));
            rd("queue", a, 32'hc0de_0000 + 32'(n));
        end
        rd("status", `CGPC_A_STATUS, 32'hf);
    endtask
    // mid-run reset: stored requests and calibration must not survive
    task automatic t_reset();
        chk("group", 8'h10, group_pstate);
        @(posedge pclk);
        presetn <= 1'h0;
        tick(2);
        chk("group", `CGPC_PS_MAX, group_pstate);
        chk("report", 32'h0, status_report);
        @(posedge pclk);
        presetn <= 1'h1;
        tick(2);
        chk("group", `CGPC_PS_MAX, group_pstate);
        chk("l3", 1'h1, l3_active);
        rd("cal", `CGPC_A_CAL, 32'h40);
    endtask
    initial
    begin
        {psel, penable, pwrite, cme_access} = 4'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        temp_raw = 10'h0;
        grid_level = 4'h0;
        n_fail = 0;
        n_compared = 0;
        ticks = 0;
        presetn = 1'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        tick(1);
        t_regs();
        t_temp();
        t_droop();
        t_pstate();
        t_idle();
        t_queue();
        t_reset();
        conclude();
    end
endmodule
